// ### stop_mode_consts.svh
`ifndef STOP_MODE_CONSTS_SVH
`define STOP_MODE_CONSTS_SVH
`define POWER_CONTROL_0_ADDR 12'hF80
`define POWER_CONTROL_0_RESET 8'h80
`define LPO_DISABLE_BIT 7
`define BROWNOUT_DISABLE_BIT 4
`define TEMP_DISABLE_BIT 3
`define ADC_DISABLE_BIT 2
`define COMP_DISABLE_BIT 1
`define POWER_CONTROL_0_WMASK 8'h9E
`endif

// ### stop_mode_pkg.sv
package stop_mode_pkg;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_STOP = 2'b01,
    PWR_RECOVER = 2'b11
  } power_state_t;
endpackage

// ### pin_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser; output changes once stages two and three agree.
module pin_sync
  import stop_mode_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic pinIn,
  output logic pinOut
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;

  // Next-state logic; stage one is read only by stage two.
  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.out = st.s3;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pinOut = st.out;
endmodule

// ### power_ctl_reg.sv
`timescale 1ns/1ns
`include "stop_mode_consts.svh"
// Power control register, set to 8'h80 only by power-on reset.
module power_ctl_reg
  import stop_mode_pkg::*;
(
  input wire logic clock,
  input wire logic powerOnReset,
  input wire logic [11:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  output logic [7:0] powerControl
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rdata;
  } reg_state_t;
  reg_state_t st;
  reg_state_t next_st;

  // Decode and update; reserved bits always read as zero.
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (writeStrobe && address == `POWER_CONTROL_0_ADDR) begin
      next_st.ctl = writeData & `POWER_CONTROL_0_WMASK;
    end
    if (readStrobe && address == `POWER_CONTROL_0_ADDR) begin
      next_st.rdata = st.ctl;
    end
  end

  // Only the power-on reset loads the 8'h80 reset value into this register; system resets do not.
  always_ff @(posedge clock) begin
    if (powerOnReset) begin
      st <= {`POWER_CONTROL_0_RESET, 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign readData = st.rdata;
  assign powerControl = st.ctl;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  reset_value_a: assert property (@(posedge clock) $past(powerOnReset) |-> powerControl == 8'h80)
    else $error("power control not at reset value after power-on reset");
  write_effect_a: assert property (@(posedge clock) disable iff (powerOnReset)
    writeStrobe && address == 12'hF80 |=> powerControl == ($past(writeData) & 8'h9E))
    else $error("power control write not stored");
  read_answer_a: assert property (@(posedge clock) disable iff (powerOnReset)
    readStrobe && address == 12'hF80 && !writeStrobe |=> readData == $past(powerControl))
    else $error("power control read data wrong");
endmodule

// ### stop_mode_power_control.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "stop_mode_consts.svh"
module stop_mode_power_control
  import stop_mode_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic powerOnReset,
  input wire logic [11:0] address,
  input wire logic [7:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [7:0] readData,
  input wire logic sleepExecute,
  input wire logic recoveryRequest,
  input wire logic recoveryDone,
  input wire logic crystalEnable,
  input wire logic sharedPinOscSelect,
  input wire logic watchdogOscEnable,
  input wire logic watchdogEnable,
  input wire logic brownout_always_on_option,
  input wire logic ampEnableLocal,
  input wire logic tempEnableLocal,
  input wire logic adcEnableLocal,
  input wire logic compEnableLocal,
  input wire logic peripheralEnableLocal,
  output logic stopActive,
  output logic systemClockEnable,
  output logic cpuRun,
  output logic crystalOscRun,
  output logic precisionOscRun,
  output logic crystalPinsEnable,
  output logic sharedPinsToGpio,
  output logic watchdogOscRun,
  output logic watchdogRun,
  output logic brownoutActive,
  output logic lowpowerAmpRun,
  output logic tempSensorRun,
  output logic adcRun,
  output logic compRun,
  output logic peripheralRun
);
  typedef struct packed {
    power_state_t mode;
    logic [13:0] outs;
    logic periph;
  } top_state_t;
  top_state_t st;
  top_state_t next_st;
  logic [7:0] powerControl;
  logic [7:0] regReadData;
  logic optionSync;
  logic lowpower_amp_disable;
  logic brownout_disable;
  logic inStop;

  // ***************************************************************
  // Register and option-pin input
  // ***************************************************************
  power_ctl_reg regs (
    .clock(clock),
    .powerOnReset(powerOnReset),
    .address(address),
    .writeData(writeData),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .readData(regReadData),
    .powerControl(powerControl)
  );

  // The option bit comes from the nonvolatile store, outside this clock domain.
  pin_sync optionSyncer (
    .clock(clock),
    .reset(reset),
    .pinIn(brownout_always_on_option),
    .pinOut(optionSync)
  );

  assign lowpower_amp_disable = powerControl[`LPO_DISABLE_BIT];
  assign brownout_disable = powerControl[`BROWNOUT_DISABLE_BIT];

  // ***************************************************************
  // Mode sequencing and block enables
  // ***************************************************************
  // Recovery is a separate step so that stop cannot end on a stray sleep or write.
  always_comb begin
    next_st = st;
    case (st.mode)
      PWR_ACTIVE: begin
        if (sleepExecute) begin
          next_st.mode = PWR_STOP;
        end
      end
      PWR_STOP: begin
        if (recoveryRequest) begin
          next_st.mode = PWR_RECOVER;
        end
      end
      PWR_RECOVER: begin
        if (recoveryDone) begin
          next_st.mode = PWR_ACTIVE;
        end
      end
      default: begin
        next_st.mode = PWR_ACTIVE;
      end
    endcase
    inStop = (next_st.mode != PWR_ACTIVE);
    next_st.outs[0] = inStop;
    next_st.outs[1] = !inStop;
    next_st.outs[2] = !inStop;
    next_st.outs[3] = !inStop && crystalEnable;
    next_st.outs[4] = !inStop;
    next_st.outs[5] = !inStop && crystalEnable;
    next_st.outs[6] = inStop || !sharedPinOscSelect;
    next_st.outs[7] = watchdogOscEnable;
    next_st.outs[8] = watchdogEnable && watchdogOscEnable;
    // Brownout needs both the register and the always-on option; in stop the option gates it.
    next_st.outs[9] = !brownout_disable && optionSync;
    // The amplifier is steered by its disable bit and its local enable, in either mode.
    next_st.outs[10] = !lowpower_amp_disable && ampEnableLocal;
    next_st.outs[11] = !inStop && tempEnableLocal && !powerControl[`TEMP_DISABLE_BIT];
    next_st.outs[12] = !inStop && adcEnableLocal && !powerControl[`ADC_DISABLE_BIT];
    next_st.outs[13] = !inStop && compEnableLocal && !powerControl[`COMP_DISABLE_BIT];
    // Every other peripheral idles whenever the device is stopped or recovering.
    next_st.periph = peripheralEnableLocal && !inStop;
  end

  // State register; system reset returns to active with every block off until enables settle.
  always_ff @(posedge clock) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Read data comes straight from the register block's flop, so it stands in the cycle after the read only.
  assign readData = regReadData;
  assign stopActive = st.outs[0];
  assign systemClockEnable = st.outs[1];
  assign cpuRun = st.outs[2];
  assign crystalOscRun = st.outs[3];
  assign precisionOscRun = st.outs[4];
  assign crystalPinsEnable = st.outs[5];
  assign sharedPinsToGpio = st.outs[6];
  assign watchdogOscRun = st.outs[7];
  assign watchdogRun = st.outs[8];
  assign brownoutActive = st.outs[9];
  assign lowpowerAmpRun = st.outs[10];
  assign tempSensorRun = st.outs[11];
  assign adcRun = st.outs[12];
  assign compRun = st.outs[13];
  assign peripheralRun = st.periph;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  sequence sleepTaken_s;
    !stopActive ##0 sleepExecute;
  endsequence
  sequence stopEntered_s;
    stopActive && !cpuRun && !systemClockEnable;
  endsequence

  stop_entry_a: assert property (@(posedge clock) disable iff (reset)
    sleepTaken_s |=> stopEntered_s)
    else $error("sleep did not enter stop");
  osc_halt_a: assert property (@(posedge clock) disable iff (reset)
    stopActive |-> !crystalOscRun && !precisionOscRun && !crystalPinsEnable && sharedPinsToGpio)
    else $error("oscillator running in stop");
  cpu_halt_a: assert property (@(posedge clock) disable iff (reset)
    stopActive |-> !cpuRun && !systemClockEnable)
    else $error("cpu running in stop");
  watchdog_gate_a: assert property (@(posedge clock) disable iff (reset)
    watchdogRun |-> watchdogOscRun && $past(watchdogEnable))
    else $error("watchdog running while disabled");
  brownout_gate_a: assert property (@(posedge clock) disable iff (reset)
    brownoutActive |-> !$past(brownout_disable))
    else $error("brownout active while disabled");
  amp_stop_a: assert property (@(posedge clock) disable iff (reset)
    stopActive && $past(ampEnableLocal) && !$past(lowpower_amp_disable) |-> lowpowerAmpRun)
    else $error("amplifier stopped while enabled");
  stop_hold_a: assert property (@(posedge clock) disable iff (reset)
    stopActive && !recoveryRequest && !recoveryDone |=> stopActive)
    else $error("stop left without recovery");
  disable_force_a: assert property (@(posedge clock) disable iff (reset)
    $past(powerControl[`ADC_DISABLE_BIT]) |-> !adcRun)
    else $error("disabled block still running");
  amp_force_a: assert property (@(posedge clock) disable iff (reset)
    $past(lowpower_amp_disable) |-> !lowpowerAmpRun)
    else $error("amplifier running while disabled");

  // ***************************************************************
  // Output tracking assertions
  // ***************************************************************
  // Outputs follow their inputs one cycle late; the edge right after reset still shows the cleared state.
  // Active mode keeps the clock, the core and the precision oscillator running.
  active_run_a: assert property (@(posedge clock) disable iff (reset)
    !stopActive && !$past(reset) |-> cpuRun && systemClockEnable && precisionOscRun)
    else $error("core stopped while active");
  // The clock gate and the core halt always move together.
  clock_core_a: assert property (@(posedge clock) disable iff (reset)
    systemClockEnable == cpuRun)
    else $error("clock gate and core disagree");
  // The crystal oscillator follows its enable while active.
  crystal_follow_a: assert property (@(posedge clock) disable iff (reset)
    !stopActive && !$past(reset) |-> crystalOscRun == $past(crystalEnable))
    else $error("crystal oscillator wrong while active");
  // The crystal pins follow the same enable while active.
  pins_follow_a: assert property (@(posedge clock) disable iff (reset)
    !stopActive && !$past(reset) |-> crystalPinsEnable == $past(crystalEnable))
    else $error("crystal pins wrong while active");
  // Shared pins belong to the oscillator only while active and selected.
  shared_pins_a: assert property (@(posedge clock) disable iff (reset)
    !stopActive && !$past(reset) |-> sharedPinsToGpio == !$past(sharedPinOscSelect))
    else $error("shared pin ownership wrong");
  // The watchdog oscillator follows its enable in every mode.
  wdosc_follow_a: assert property (@(posedge clock) disable iff (reset)
    !$past(reset) |-> watchdogOscRun == $past(watchdogOscEnable))
    else $error("watchdog oscillator wrong");
  // Watchdog logic needs its own enable and its oscillator.
  wdrun_follow_a: assert property (@(posedge clock) disable iff (reset)
    !$past(reset) |-> watchdogRun == ($past(watchdogEnable) && $past(watchdogOscEnable)))
    else $error("watchdog logic wrong");
  // Brownout needs the register bit clear and the synchronised option set.
  brownout_follow_a: assert property (@(posedge clock) disable iff (reset)
    !$past(reset) |-> brownoutActive == (!$past(brownout_disable) && $past(optionSync)))
    else $error("brownout state wrong");
  // The amplifier follows its disable bit and local enable in either mode.
  amp_follow_a: assert property (@(posedge clock) disable iff (reset)
    !$past(reset) |-> lowpowerAmpRun == (!$past(lowpower_amp_disable) && $past(ampEnableLocal)))
    else $error("amplifier state wrong");
  // All other peripherals idle in stop and recovery.
  idle_in_stop_a: assert property (@(posedge clock) disable iff (reset)
    stopActive |-> !tempSensorRun && !adcRun && !compRun && !peripheralRun)
    else $error("peripheral running in stop");
  // A set temperature bit forces the sensor off.
  temp_force_a: assert property (@(posedge clock) disable iff (reset)
    $past(powerControl[`TEMP_DISABLE_BIT]) |-> !tempSensorRun)
    else $error("temperature sensor running while disabled");
  // A set comparator bit forces the comparator off.
  comp_force_a: assert property (@(posedge clock) disable iff (reset)
    $past(powerControl[`COMP_DISABLE_BIT]) |-> !compRun)
    else $error("comparator running while disabled");
  // Each analog block runs only on its own enable.
  temp_need_a: assert property (@(posedge clock) disable iff (reset)
    tempSensorRun |-> $past(tempEnableLocal) && !stopActive)
    else $error("temperature sensor running without enable");
  adc_need_a: assert property (@(posedge clock) disable iff (reset)
    adcRun |-> $past(adcEnableLocal) && !stopActive)
    else $error("converter running without enable");
  comp_need_a: assert property (@(posedge clock) disable iff (reset)
    compRun |-> $past(compEnableLocal) && !stopActive)
    else $error("comparator running without enable");
  periph_need_a: assert property (@(posedge clock) disable iff (reset)
    peripheralRun |-> $past(peripheralEnableLocal) && !stopActive)
    else $error("peripheral running without enable");
  // A system reset leaves every block off at the next edge.
  reset_clear_a: assert property (@(posedge clock) disable iff (reset)
    $past(reset) |-> !stopActive && !cpuRun && !lowpowerAmpRun && !brownoutActive)
    else $error("outputs not cleared by reset");

  // ***************************************************************
  // Mode sequencing assertions
  // ***************************************************************
  // The unused encoding must never be reached.
  mode_legal_a: assert property (@(posedge clock) disable iff (reset)
    st.mode != 2'b10)
    else $error("illegal power mode");
  // A sleep seen while stopped changes nothing.
  sleep_ignored_a: assert property (@(posedge clock) disable iff (reset)
    st.mode == PWR_STOP && !recoveryRequest |=> st.mode == PWR_STOP)
    else $error("stop left without request");
  // Recovery holds until it is reported done.
  recover_wait_a: assert property (@(posedge clock) disable iff (reset)
    st.mode == PWR_RECOVER && !recoveryDone |=> st.mode == PWR_RECOVER)
    else $error("recovery ended early");
  // Completion of recovery returns the device to active.
  recover_exit_a: assert property (@(posedge clock) disable iff (reset)
    st.mode == PWR_RECOVER && recoveryDone |=> !stopActive && cpuRun)
    else $error("recovery did not return to active");
endmodule

// ### cpu_model.sv
`timescale 1ns/1ns
// ********************
// Processor core model
// ********************
module cpu_model (
  input wire logic clock,
  output logic [11:0] address,
  output logic [7:0] writeData,
  output logic writeStrobe,
  output logic readStrobe,
  input wire logic [7:0] readData,
  output logic sleepExecute,
  output logic recoveryRequest,
  output logic recoveryDone
);
  // Idle state of all core outputs.
  initial begin
    address = 12'h000;
    writeData = 8'h00;
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    sleepExecute = 1'b0;
    recoveryRequest = 1'b0;
    recoveryDone = 1'b0;
  end
  // One-cycle write; reserved bits are always sent as zero.
  task automatic regWrite(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d & 8'h9E;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    address <= ~a;
    writeData <= ~d;
  endtask
  // One-cycle read; the data are valid only in the following cycle.
  task automatic regRead(input logic [11:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    address <= ~a;
    #1;
    d = readData;
  endtask
  // The sleep instruction is a single-cycle pulse.
  task automatic sleep();
    @(posedge clock);
    sleepExecute <= 1'b1;
    @(posedge clock);
    sleepExecute <= 1'b0;
  endtask
  // Recovery request, a chosen delay, then completion.
  task automatic recover(input int gap);
    @(posedge clock);
    recoveryRequest <= 1'b1;
    @(posedge clock);
    recoveryRequest <= 1'b0;
    repeat (gap) @(posedge clock);
    recoveryDone <= 1'b1;
    @(posedge clock);
    recoveryDone <= 1'b0;
  endtask
endmodule

// ### stop_mode_power_control_bench.sv
`timescale 1ns/1ns
module stop_mode_power_control_bench;
  logic clock;
  logic reset;
  logic powerOnReset;
  logic boOpt;
  logic [8:0] en;
  logic [7:0] d;
  wire [11:0] address;
  wire [7:0] writeData;
  wire [7:0] readData;
  wire writeStrobe;
  wire readStrobe;
  wire sleepExecute;
  wire recoveryRequest;
  wire recoveryDone;
  wire [14:0] st;
  int err_total;
  int num_checks;
  int cycles;
  // ****************
  // Clock and parts
  // ****************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  cpu_model cpu (.clock(clock), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .sleepExecute(sleepExecute),
    .recoveryRequest(recoveryRequest), .recoveryDone(recoveryDone));
  stop_mode_power_control dut_u (.clock(clock), .reset(reset), .powerOnReset(powerOnReset),
    .address(address), .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .readData(readData), .sleepExecute(sleepExecute), .recoveryRequest(recoveryRequest),
    .recoveryDone(recoveryDone), .crystalEnable(en[0]), .sharedPinOscSelect(en[1]),
    .watchdogOscEnable(en[2]), .watchdogEnable(en[3]), .brownout_always_on_option(boOpt),
    .ampEnableLocal(en[4]), .tempEnableLocal(en[5]), .adcEnableLocal(en[6]), .compEnableLocal(en[7]),
    .peripheralEnableLocal(en[8]), .stopActive(st[14]), .systemClockEnable(st[13]), .cpuRun(st[12]),
    .crystalOscRun(st[11]), .precisionOscRun(st[10]), .crystalPinsEnable(st[9]),
    .sharedPinsToGpio(st[8]), .watchdogOscRun(st[7]), .watchdogRun(st[6]), .brownoutActive(st[5]),
    .lowpowerAmpRun(st[4]), .tempSensorRun(st[3]), .adcRun(st[2]), .compRun(st[1]),
    .peripheralRun(st[0]));
  // ****************
  // Helpers
  // ****************
  // Masked compare; case inequality lets no unknown slip through.
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input logic [14:0] m);
    num_checks++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The run should need under a hundred cycles; a hang is cut well beyond that.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end
  // ****************
  // Scenarios
  // ****************
  // After power-on only the amplifier is held off; the rest follow their enables.
  task automatic t_por();
    cpu.regRead(12'hF80, d);
    chk({7'h00, d}, 15'h0080, 15'h00FF);
    chk(st, 15'h3CEF, 15'h7DFF);
  endtask
  // Disable bits override local enables; unmapped writes land nowhere.
  task automatic t_disable();
    cpu.regWrite(12'hF81, 8'hFF);
    cpu.regWrite(12'hF80, 8'h1E);
    cpu.regRead(12'hF81, d);
    chk({7'h00, d}, 15'h0000, 15'h00FF);
    cpu.regRead(12'hF80, d);
    chk({7'h00, d}, 15'h001E, 15'h00FF);
    settle(1);
    chk(st, 15'h3CD1, 15'h7DFF);
  endtask
  // A system reset keeps the register; only power-on reset restores it.
  task automatic t_resets();
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    cpu.regRead(12'hF80, d);
    chk({7'h00, d}, 15'h001E, 15'h00FF);
    @(posedge clock);
    powerOnReset <= 1'b1;
    @(posedge clock);
    powerOnReset <= 1'b0;
    cpu.regRead(12'hF80, d);
    chk({7'h00, d}, 15'h0080, 15'h00FF);
  endtask
  // Stop entry, blocks kept alive by their enables, and exit by recovery only.
  task automatic t_stop(input logic [7:0] pc);
    logic [14:0] amp;
    amp = pc[7] ? 15'h0000 : 15'h0010;
    cpu.regWrite(12'hF80, pc);
    @(posedge clock);
    en <= 9'h1F7;
    boOpt <= 1'b1;
    cpu.sleep();
    settle(2);
    chk(st, 15'h41A0 | amp, 15'h7FFF);
    @(posedge clock);
    en <= 9'h1F3;
    boOpt <= 1'b0;
    settle(6);
    chk(st, 15'h4100 | amp, 15'h7FFF);
    fork
      cpu.recover(6);
      begin
        settle(5);
        chk(st, 15'h4000, 15'h7000);
      end
    join
    settle(1);
    chk(st, 15'h3000, 15'h7000);
    @(posedge clock);
    en <= 9'h1FF;
    boOpt <= 1'b1;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    reset = 1'b1;
    powerOnReset = 1'b1;
    boOpt = 1'b1;
    en = 9'h1FF;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    powerOnReset <= 1'b0;
    settle(6);
    t_por();
    t_disable();
    t_resets();
    t_stop(8'h00);
    t_stop(8'h80);
    stop_test();
  end
endmodule
